// *** hpg_map.svh ***
// Purpose: constants for the host port strap and interrupt glue
// Assumes: 250 MHz core clock
// Notes: all figures as named macros
`ifndef HPG_MAP_SVH
`define HPG_MAP_SVH

// ==========================================================
// primary mode codes
`define HPG_MD_PAR_OSC 3'h4
`define HPG_MD_PAR_EXT 3'h5
`define HPG_MD_SERIAL 3'h6

// ==========================================================
// field positions of the expansion and serial straps
`define HPG_MDE_MUX_BIT 2
`define HPG_MDE_TYPE_BIT 0
`define HPG_MDS_LSBF_BIT 2
`define HPG_MDS_CPOL_BIT 1
`define HPG_MDS_CPHA_BIT 0

// ==========================================================
// timing
`define HPG_CLK_MHZ 250
`define HPG_TMR_PULSE_NS 1000
`define HPG_TMR_PULSE_CYC ((`HPG_TMR_PULSE_NS * `HPG_CLK_MHZ) / 1000)
`define HPG_STRAP_SETTLE 2'h3

// ==========================================================
// half-word addressing
`define HPG_HALF_SEL_BIT 1

`endif

// *** hpg_pkg.sv ***
// Purpose: types for the host port strap and interrupt glue
// Assumes: nothing
// Notes: none
package hpg_pkg;
  typedef enum logic [1:0] {
    HPG_MODE_PAR_OSC,
    HPG_MODE_PAR_EXT,
    HPG_MODE_SERIAL,
    HPG_MODE_PROHIB
  } hpg_mode_e;

  typedef enum logic {
    HPG_HALF_EMPTY,
    HPG_HALF_HELD
  } hpg_half_e;
endpackage

// *** hpg_pulse.sv ***
// Purpose: fixed-width pulse from a one-cycle timer event
// Assumes: event is on the core clock
// Notes: a new event restarts the pulse
`timescale 1ns/1ps
`default_nettype none
`include "hpg_map.svh"
module hpg_pulse (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // event in, pulse out
  input wire logic event_in,
  output logic pulse_out
);
  localparam int unsigned WIDTH = `HPG_TMR_PULSE_CYC;
  logic [8:0] count_ff;
  logic [8:0] nxt_count;

  // ==========================================================
  // countdown
  always_comb begin
    nxt_count = count_ff;
    if (event_in) begin
      nxt_count = 9'(WIDTH);
    end else if (count_ff != 9'h000) begin
      nxt_count = count_ff - 9'h001;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= 9'h000;
    end else if (clk_en) begin
      count_ff <= nxt_count;
    end
  end

  assign pulse_out = (count_ff != 9'h000);
endmodule
`default_nettype wire

// *** hpg_top.sv ***
// Purpose: strap decode, interrupt pin routing, 16-to-32 write pairing
// Assumes: one core clock, straps are pins, controller side on core clock
// Notes: configuration frozen until next reset
// Behaviour
// - decode primary straps into port mode
// - serial straps only count in serial mode
// - serial frequency code from upper expansion straps
// - lowest expansion strap zero selects SPI
// - top serial strap sets LSB first
// - middle serial strap sets clock polarity
// - lowest serial strap sets clock phase
// - pin a follows line zero when enabled
// - pin b follows line one when enabled
// - non-mux: pin c ORs timers and low-voltage
// - mux or SPI: timers, low-voltage on c,d,e
// - enabled pin high while pending, else low
// - timer pins give fixed-width pulses
// - hold low half, commit on high half
`timescale 1ns/1ps
`default_nettype none
`include "hpg_map.svh"
module hpg_top
  import hpg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // strap pins
  input wire logic [2:0] primary_mode_strap,
  input wire logic [2:0] mode_expansion_strap,
  input wire logic [2:0] serial_setting_strap,
  // decoded configuration
  output logic cfg_valid,
  output logic mode_par_osc,
  output logic mode_par_ext,
  output logic mode_serial,
  output logic mode_prohibited,
  output logic mode_multiplexed,
  output logic [1:0] serial_freq_sel,
  output logic spi_selected,
  output logic serial_type_reserved,
  output logic lsb_first_select,
  output logic spi_cpol,
  output logic spi_cpha,
  // controller interrupt sources
  input wire logic cc_irq_line_zero,
  input wire logic cc_irq_line_one,
  input wire logic [1:0] irq_line_enable,
  input wire logic timer0_event,
  input wire logic timer1_event,
  input wire logic low_voltage_det,
  // interrupt pins
  output logic irq_out_a,
  output logic irq_out_b,
  output logic irq_out_c,
  output logic irq_out_d,
  output logic irq_out_e,
  // host half-word access
  input wire logic hw_wr,
  input wire logic hw_rd,
  input wire logic [15:0] hw_addr,
  input wire logic [15:0] hw_wdata,
  output logic [15:0] hw_rdata,
  output logic hw_rdata_valid,
  // controller word access
  output logic cc_wr,
  output logic cc_rd,
  output logic [13:0] cc_addr,
  output logic [31:0] cc_wdata,
  input wire logic [31:0] cc_rdata
);
  // ==========================================================
  // strap synchroniser and one-time capture
  logic [8:0] strap_meta_ff;
  logic [8:0] strap_sync_ff;
  logic [1:0] settle_ff;
  logic [1:0] nxt_settle;
  logic captured_ff;
  logic nxt_captured;
  logic [8:0] strap_ff;
  logic [8:0] nxt_strap;

  always_comb begin
    nxt_settle = settle_ff;
    nxt_captured = captured_ff;
    nxt_strap = strap_ff;
    if (!captured_ff) begin
      if (settle_ff == `HPG_STRAP_SETTLE) begin
        nxt_captured = 1'b1;
        nxt_strap = strap_sync_ff;
      end else begin
        nxt_settle = settle_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_ff <= 9'h000;
      strap_sync_ff <= 9'h000;
      settle_ff <= 2'h0;
      captured_ff <= 1'b0;
      strap_ff <= 9'h000;
    end else if (clk_en) begin
      strap_meta_ff <= {primary_mode_strap, mode_expansion_strap, serial_setting_strap};
      strap_sync_ff <= strap_meta_ff;
      settle_ff <= nxt_settle;
      captured_ff <= nxt_captured;
      strap_ff <= nxt_strap;
    end
  end

  // ==========================================================
  // mode decode
  logic [2:0] md;
  logic [2:0] mde;
  logic [2:0] mds;
  hpg_mode_e mode;
  logic spi_on;

  assign md = strap_ff[8:6];
  assign mde = strap_ff[5:3];
  assign mds = strap_ff[2:0];

  always_comb begin
    unique case (md)
      `HPG_MD_PAR_OSC: mode = HPG_MODE_PAR_OSC;
      `HPG_MD_PAR_EXT: mode = HPG_MODE_PAR_EXT;
      `HPG_MD_SERIAL: mode = HPG_MODE_SERIAL;
      default: mode = HPG_MODE_PROHIB;
    endcase
  end

  assign cfg_valid = captured_ff;
  assign mode_par_osc = captured_ff && (mode == HPG_MODE_PAR_OSC);
  assign mode_par_ext = captured_ff && (mode == HPG_MODE_PAR_EXT);
  assign mode_serial = captured_ff && (mode == HPG_MODE_SERIAL);
  assign mode_prohibited = captured_ff && (mode == HPG_MODE_PROHIB);
  assign mode_multiplexed = (mode_par_osc || mode_par_ext) && !mde[`HPG_MDE_MUX_BIT];
  assign serial_freq_sel = mode_serial ? mde[2:1] : 2'h0;
  assign spi_on = mode_serial && !mde[`HPG_MDE_TYPE_BIT];
  assign spi_selected = spi_on;
  assign serial_type_reserved = mode_serial && mde[`HPG_MDE_TYPE_BIT];
  assign lsb_first_select = spi_on && mds[`HPG_MDS_LSBF_BIT];
  assign spi_cpol = spi_on && mds[`HPG_MDS_CPOL_BIT];
  assign spi_cpha = spi_on && mds[`HPG_MDS_CPHA_BIT];

  // ==========================================================
  // timer pulse stretchers
  logic [1:0] tmr_evt;
  logic [1:0] tmr_pulse;
  assign tmr_evt = {timer1_event, timer0_event};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      hpg_pulse u_pulse (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .event_in(tmr_evt[gi]),
        .pulse_out(tmr_pulse[gi])
      );
    end
  endgenerate

  // ==========================================================
  // interrupt pin routing
  logic [4:0] irq_ff;
  logic [4:0] nxt_irq;
  logic split_pins;
  logic nonmux_pins;

  assign split_pins = mode_multiplexed || spi_on;
  assign nonmux_pins = (mode_par_osc || mode_par_ext) && !mode_multiplexed;

  always_comb begin
    nxt_irq = 5'h00;
    nxt_irq[0] = cc_irq_line_zero && irq_line_enable[0];
    nxt_irq[1] = cc_irq_line_one && irq_line_enable[1];
    if (nonmux_pins) begin
      nxt_irq[2] = tmr_pulse[0] || tmr_pulse[1] || low_voltage_det;
    end else if (split_pins) begin
      nxt_irq[2] = tmr_pulse[0];
      nxt_irq[3] = tmr_pulse[1];
      nxt_irq[4] = low_voltage_det;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 5'h00;
    end else if (clk_en) begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_out_a = irq_ff[0];
  assign irq_out_b = irq_ff[1];
  assign irq_out_c = irq_ff[2];
  assign irq_out_d = irq_ff[3];
  assign irq_out_e = irq_ff[4];

  // ==========================================================
  // half-word pairing
  logic [15:0] wr_hold_ff;
  logic [15:0] nxt_wr_hold;
  logic [15:0] rd_hold_ff;
  logic [15:0] nxt_rd_hold;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic upper_half;

  assign upper_half = hw_addr[`HPG_HALF_SEL_BIT];
  assign cc_addr = hw_addr[15:2];
  assign cc_wr = clk_en && hw_wr && upper_half;
  assign cc_wdata = {wr_hold_ff, hw_wdata};
  assign cc_rd = clk_en && hw_rd && !hw_wr && !upper_half;

  always_comb begin
    nxt_wr_hold = wr_hold_ff;
    nxt_rd_hold = rd_hold_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (hw_wr) begin
      if (!upper_half) begin
        nxt_wr_hold = hw_wdata;
      end
    end else if (hw_rd) begin
      nxt_rvalid = 1'b1;
      if (!upper_half) begin
        nxt_rdata = cc_rdata[31:16];
        nxt_rd_hold = cc_rdata[15:0];
      end else begin
        nxt_rdata = rd_hold_ff;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_hold_ff <= 16'h0000;
      rd_hold_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else if (clk_en) begin
      wr_hold_ff <= nxt_wr_hold;
      rd_hold_ff <= nxt_rd_hold;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign hw_rdata = rdata_ff;
  assign hw_rdata_valid = rvalid_ff;
endmodule
`default_nettype wire

// *** hpg_asserts.sv ***
// Purpose: port checks for hpg_top
// Assumes: one clock, clk_en mostly high
// Notes: bound from the bench
`timescale 1ns/1ps
`default_nettype none
`include "hpg_map.svh"
module hpg_asserts (
  // control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic mode_serial,
  input wire logic mode_multiplexed,
  input wire logic spi_selected,
  input wire logic [1:0] serial_freq_sel,
  // pins and ports
  input wire logic cc_irq_line_zero,
  input wire logic cc_irq_line_one,
  input wire logic [1:0] irq_line_enable,
  input wire logic irq_out_a,
  input wire logic irq_out_b,
  input wire logic irq_out_c,
  input wire logic hw_wr,
  input wire logic hw_rd,
  input wire logic [15:0] hw_addr,
  input wire logic [15:0] hw_wdata,
  input wire logic [15:0] hw_rdata,
  input wire logic hw_rdata_valid,
  input wire logic cc_wr,
  input wire logic cc_rd,
  input wire logic [31:0] cc_wdata,
  input wire logic [31:0] cc_rdata
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // ====================
  // held halves, pulse length
  logic [15:0] held_ff, cap_ff;
  logic [8:0] hi_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      held_ff <= '0;
      cap_ff <= '0;
      hi_ff <= '0;
    end else if (clk_en) begin
      if (hw_wr && !hw_addr[1]) held_ff <= hw_wdata;
      if (cc_rd) cap_ff <= cc_rdata[15:0];
      hi_ff <= irq_out_c ? hi_ff + 9'h1 : 9'h0;
    end
  end
  // ====================
  // properties
  a_pin_a_follow: assert property (
    $past(clk_en) && $past(reset_n) |->
    irq_out_a == ($past(cc_irq_line_zero) && $past(irq_line_enable[0])))
    else $error("pin a wrong");
  a_pin_b_follow: assert property (
    $past(clk_en) && $past(reset_n) |->
    irq_out_b == ($past(cc_irq_line_one) && $past(irq_line_enable[1])))
    else $error("pin b wrong");
  a_low_held: assert property (clk_en && hw_wr && !hw_addr[1] |-> !cc_wr)
    else $error("low half committed");
  a_high_commit: assert property (
    clk_en && hw_wr && hw_addr[1] |-> cc_wr && cc_wdata == {held_ff, hw_wdata})
    else $error("high half commit wrong");
  a_low_read: assert property (
    clk_en && hw_rd && !hw_wr && !hw_addr[1] |->
    cc_rd ##1 hw_rdata_valid && hw_rdata == $past(cc_rdata[31:16]))
    else $error("low read wrong");
  a_high_read: assert property (
    clk_en && hw_rd && !hw_wr && hw_addr[1] |=> hw_rdata_valid && hw_rdata == cap_ff)
    else $error("high read wrong");
  a_serial_gated: assert property (!mode_serial |-> serial_freq_sel == 2'h0)
    else $error("serial field outside serial mode");
  a_timer_width: assert property (
    $fell(irq_out_c) && (spi_selected || mode_multiplexed) |-> hi_ff == 9'(`HPG_TMR_PULSE_CYC))
    else $error("timer pulse width wrong");
endmodule
`default_nettype wire

// *** hpg_host.sv ***
// Purpose: host model on the half-word port
// Assumes: requests change just after a rising edge
// Notes: released lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module hpg_host (
  // clock
  input wire logic clock,
  // half-word port
  output logic hw_wr,
  output logic hw_rd,
  output logic [15:0] hw_addr,
  output logic [15:0] hw_wdata,
  input wire logic [15:0] hw_rdata,
  input wire logic hw_rdata_valid
);
  logic [15:0] got[$];
  initial begin
    hw_wr = 1'h0;
    hw_rd = 1'h0;
    hw_addr = '0;
    hw_wdata = '0;
  end
  always @(posedge clock) begin
    if (hw_rdata_valid) got.push_back(hw_rdata);
  end
  task automatic half(input logic wr, input logic [15:0] a, d);
    hw_wr <= wr;
    hw_rd <= !wr;
    hw_addr <= a;
    hw_wdata <= d;
    @(posedge clock);
  endtask
  task automatic idle;
    hw_wr <= 1'h0;
    hw_rd <= 1'h0;
    hw_addr <= ~hw_addr;
    hw_wdata <= ~hw_wdata;
    @(posedge clock);
  endtask
  // low half then high half, back to back
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    half(1'h1, a, d[31:16]);
    half(1'h1, a | 16'h2, d[15:0]);
    idle;
  endtask
  task automatic rd32(input logic [15:0] a, output logic [31:0] d);
    got.delete();
    half(1'h0, a, hw_wdata);
    half(1'h0, a | 16'h2, hw_wdata);
    idle;
    @(posedge clock);
    d = (got.size() == 2) ? {got[0], got[1]} : 'x;
  endtask
endmodule
`default_nettype wire

// *** hpg_top_bench.sv ***
// Purpose: self-checking bench for hpg_top
// Assumes: clk_en held high except for the one frozen write in t_write
// Notes: host model drives the half-word port
`timescale 1ns/1ps
`default_nettype none
`include "hpg_map.svh"
module hpg_top_bench;
  logic clock = 0, reset_n = 0, clk_en = 1, cc_irq_line_zero = 0, cc_irq_line_one = 0;
  logic timer0_event = 0, timer1_event = 0, low_voltage_det = 0, hw_wr, hw_rd, cc_wr;
  logic [2:0] primary_mode_strap = 0, mode_expansion_strap = 0, serial_setting_strap = 0;
  logic hw_rdata_valid, cfg_valid, mode_par_osc, mode_par_ext, mode_serial, cc_rd;
  logic mode_prohibited, mode_multiplexed, spi_selected, serial_type_reserved;
  logic lsb_first_select, spi_cpol, spi_cpha, irq_out_a, irq_out_b, irq_out_c, irq_out_d;
  logic irq_out_e;
  logic [1:0] irq_line_enable = 0, serial_freq_sel;
  logic [15:0] hw_addr, hw_wdata, hw_rdata;
  logic [13:0] cc_addr, last_addr;
  logic [31:0] cc_wdata, last_data, rd_word = 32'h8C3E_51A7;
  wire logic [31:0] cc_rdata = cc_rd ? rd_word : ~rd_word;
  int errors = 0, comparisons = 0, cycles = 0, writes = 0;
  hpg_top i_hpg_top (.*);
  hpg_host i_hpg_host (.*);
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cc_wr) begin
      writes++;
      last_addr = cc_addr;
      last_data = cc_wdata;
    end
    if (cycles == 20000) begin
      errors++;
      finish_test;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic boot(input logic [2:0] p, e, s);
    reset_n <= 0;
    {primary_mode_strap, mode_expansion_strap, serial_setting_strap} <= {p, e, s};
    repeat (6) @(posedge clock);
    reset_n <= 1;
    repeat (6) @(posedge clock);
    check("cfg_valid", cfg_valid, 1);
    {primary_mode_strap, mode_expansion_strap, serial_setting_strap} <= ~{p, e, s};
    repeat (4) @(posedge clock);
  endtask
  task automatic t_straps;
    logic [2:0] p, e, s;
    logic ser, spi;
    logic [7:0] x;
    for (int i = 0; i < 10; i++) begin
      p = (i >= 8) ? 3'h6 : 3'(i);
      e = (i == 8) ? 3'h7 : (i == 9) ? 3'h4 : 3'(i * 3);
      s = 3'(i * 5);
      boot(p, e, s);
      ser = (p == `HPG_MD_SERIAL);
      spi = ser & !e[0];
      x = {3'h0, p == `HPG_MD_PAR_OSC, p == `HPG_MD_PAR_EXT, ser, p < 4 || p == 7, p[2:1] == 2'h2 && !e[2]};
      check("mode", {mode_par_osc, mode_par_ext, mode_serial, mode_prohibited, mode_multiplexed}, x);
      x = {ser ? e[2:1] : 2'h0, spi, ser & e[0], 1'h0, spi ? s : 3'h0};
      check("serial", {serial_freq_sel, spi_selected, serial_type_reserved, 1'h0, lsb_first_select, spi_cpol, spi_cpha}, x);
    end
  endtask
  task automatic fire(input int src, input int pin);
    int n[3];
    int r[3];
    logic [2:0] v;
    logic [2:0] q;
    n = '{0, 0, 0};
    r = '{0, 0, 0};
    q = {irq_out_e, irq_out_d, irq_out_c};
    timer0_event <= (src == 0);
    timer1_event <= (src == 1);
    low_voltage_det <= (src == 2);
    for (int c = 0; c < 300; c++) begin
      @(posedge clock);
      if (c == 0) begin
        timer0_event <= 0;
        timer1_event <= 0;
      end
      if (c == 9) low_voltage_det <= 0;
      v = {irq_out_e, irq_out_d, irq_out_c};
      for (int j = 0; j < 3; j++) begin
        n[j] += v[j];
        r[j] += (v[j] && !q[j]);
      end
      q = v;
    end
    for (int j = 0; j < 3; j++) check("pulse", n[j], (j == pin) ? (src == 2 ? 10 : `HPG_TMR_PULSE_CYC) : 0);
    for (int j = 0; j < 3; j++) check("edges", r[j], j == pin);
  endtask
  task automatic t_irq;
    boot(3'h4, 3'h0, 3'h0);
    for (int s = 0; s < 3; s++) fire(s, s);
    boot(3'h6, 3'h2, 3'h0);
    for (int s = 0; s < 3; s++) fire(s, s);
    boot(3'h5, 3'h4, 3'h0);
    for (int s = 0; s < 3; s++) fire(s, 0);
    boot(3'h7, 3'h0, 3'h0);
    fire(0, -1);
    boot(3'h6, 3'h1, 3'h0);
    fire(2, -1);
  endtask
  task automatic t_lines;
    for (int i = 0; i < 17; i++) begin
      {cc_irq_line_one, cc_irq_line_zero, irq_line_enable} <= 4'(i);
      repeat (2) @(posedge clock);
      check("line_pins", {irq_out_b, irq_out_a}, {i[3] & i[1], i[2] & i[0]});
    end
  endtask
  task automatic t_write;
    boot(3'h4, 3'h0, 3'h0);
    writes = 0;
    i_hpg_host.wr32(16'h0400, 32'h1234_5678);
    check("wr_data", last_data, 32'h1234_5678);
    check("wr_addr", last_addr, 32'h100);
    i_hpg_host.half(1'h1, 16'h0410, 16'hBEEF);
    i_hpg_host.idle;
    check("wr_count", writes, 1);
    i_hpg_host.half(1'h1, 16'h0412, 16'h0001);
    i_hpg_host.idle;
    check("wr_late", last_data, 32'hBEEF_0001);
    clk_en <= 0;
    i_hpg_host.half(1'h1, 16'h0402, 16'h0002);
    i_hpg_host.idle;
    clk_en <= 1;
    check("wr_frozen", writes, 2);
  endtask
  task automatic t_read;
    logic [31:0] d;
    i_hpg_host.rd32(16'h0400, d);
    check("rd_word", d, rd_word);
  endtask
  initial begin
    t_straps;
    t_irq;
    t_lines;
    t_write;
    t_read;
    finish_test;
  end
endmodule
bind hpg_top hpg_asserts i_hpg_asserts (.*);
`default_nettype wire
